/* File: eoc_interrupt_reporting.sv */
`timescale 1ns/1ps
`include "eoc_consts.svh"

// Behaviour
// - Low limit exponent top bits equal 11b select end-of-conversion mode.
// - In end-of-conversion mode every finished measurement makes interrupt active.
// - Config read makes interrupt inactive in that mode; alert response does so only when latched.
// - Latched, high fault: high flag set, low kept, interrupt, ready set.
// - Latched, low fault: low flag set, high kept, interrupt, ready set.
// - Conversion without fault sets ready; it activates interrupt only in end-of-conversion mode.
// - Config read clears ready; when latched it also clears both flags and interrupt.
// - Config write to shutdown changes no flag or ready; interrupt kept unless the write turns latching off.
// - Config write, not shutdown: ready cleared, flags kept, interrupt kept unless latching turns off or mode is transparent end-of-conversion.
// - Latched, alert response deactivates interrupt, keeps flags and ready.
// - Latch select picks latched window or transparent hysteresis reporting.
// - Pin low when active with polarity 0 or inactive with polarity 1.
// - Fault reported only after 1, 2, 4 or 8 consecutive failing results, for fault count codes 0 to 3.
module eoc_interrupt_reporting
  import eoc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        meas_done_i,
  input  wire limit_t      result_i,
  output logic             int_o,
  output logic             irq_o
);

  conv_mode_t conv_mode;
  logic [3:0] range_number;
  logic       conversion_time;
  logic       latch_sel;
  logic       irq_polarity;
  logic [1:0] fault_count;
  limit_t     low_limit;
  limit_t     high_limit;
  limit_t     last_result;
  logic       flag_high;
  logic       flag_low;
  logic       conv_ready;
  logic       int_active;
  logic [`IRQ_W-1:0] irq_stat;
  logic [`IRQ_W-1:0] irq_mask;

  logic        wb_req;
  logic        wr;
  logic        rd;
  logic        cfg_rd;
  logic        cfg_wr;
  logic        alert_ev;
  logic        eoc_mode;
  logic        high_trip;
  logic        low_trip;
  conv_mode_t  next_mode;
  logic        next_latch;
  logic        non_shut;
  logic        next_int_active;
  logic        next_flag_high;
  logic        next_flag_low;
  logic        next_conv_ready;
  logic [31:0] next_dat;
  logic [`IRQ_W-1:0] irq_ev;
  logic [`IRQ_W-1:0] irq_clr;

  // Bus decode; a request is taken once, in the cycle before ack
  assign wb_req   = cyc_i & stb_i & ~ack_o;
  assign wr       = wb_req & we_i;
  assign rd       = wb_req & ~we_i;
  assign cfg_rd   = rd & (adr_i == `CFG_OFS);
  assign cfg_wr   = wr & (adr_i == `CFG_OFS) & (sel_i[0] | sel_i[1]);
  assign alert_ev = wr & (adr_i == `ALERT_OFS);

  assign eoc_mode = low_limit[`LE_TOP_MSB:`LE_TOP_LSB] == `EOC_CODE;

  assign next_mode  = sel_i[1] ?
                      conv_mode_t'(dat_i[`CFG_M_MSB:`CFG_M_LSB]) : conv_mode;
  assign next_latch = sel_i[0] ? dat_i[`CFG_LATCH_BIT] : latch_sel;
  assign non_shut   = next_mode != MODE_SHUTDOWN;

  fault_filter u_filter (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .meas_done_i   (meas_done_i),
    .result_i      (result_i),
    .high_limit_i  (high_limit),
    .low_limit_i   (low_limit),
    .fault_count_i (fault_count),
    .high_trip_o   (high_trip),
    .low_trip_o    (low_trip)
  );

  // Interrupt state; a conversion in the same cycle as a clear wins
  always_comb begin
    next_int_active = int_active;
    if (latch_sel) begin
      if (cfg_rd || alert_ev) begin
        next_int_active = 1'b0;
      end
      if (cfg_wr && !next_latch) begin
        next_int_active = 1'b0;
      end
    end else if (eoc_mode && (cfg_rd || (cfg_wr && non_shut))) begin
      next_int_active = 1'b0;
    end
    if (meas_done_i) begin
      if (latch_sel) begin
        if (high_trip || low_trip || eoc_mode) begin
          next_int_active = 1'b1;
        end
      end else if (high_trip) begin
        next_int_active = 1'b1;
      end else if (low_trip) begin
        // Hysteresis drops the line, unless every conversion reports
        next_int_active = eoc_mode;
      end else if (eoc_mode) begin
        next_int_active = 1'b1;
      end
    end
  end

  // Flags: latched until read, or transparent comparison state
  always_comb begin
    next_flag_high = flag_high;
    next_flag_low  = flag_low;
    if (latch_sel && cfg_rd) begin
      next_flag_high = 1'b0;
      next_flag_low  = 1'b0;
    end
    if (meas_done_i) begin
      if (latch_sel) begin
        if (high_trip) begin
          next_flag_high = 1'b1;
        end
        if (low_trip) begin
          next_flag_low = 1'b1;
        end
      end else if (high_trip) begin
        next_flag_high = 1'b1;
        next_flag_low  = 1'b0;
      end else if (low_trip) begin
        next_flag_high = 1'b0;
        next_flag_low  = 1'b1;
      end
    end
  end

  // Shutdown writes leave ready alone; other config writes and config reads clear it
  always_comb begin
    next_conv_ready = conv_ready;
    if (cfg_rd || (cfg_wr && non_shut)) begin
      next_conv_ready = 1'b0;
    end
    if (meas_done_i) begin
      next_conv_ready = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_active <= 1'b0;
      flag_high  <= 1'b0;
      flag_low   <= 1'b0;
      conv_ready <= 1'b0;
    end else if (ce_i) begin
      int_active <= next_int_active;
      flag_high  <= next_flag_high;
      flag_low   <= next_flag_low;
      conv_ready <= next_conv_ready;
    end
  end

  // Pin level lags the active state by one register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_o <= 1'b1;
    end else if (ce_i) begin
      int_o <= irq_polarity ? int_active : ~int_active;
    end
  end

  // Configuration and limit registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_mode       <= MODE_SHUTDOWN;
      range_number    <= `RN_RST;
      conversion_time <= `CT_RST;
      latch_sel       <= `LATCH_RST;
      irq_polarity    <= `POL_RST;
      fault_count     <= `FC_RST;
    end else if (ce_i && cfg_wr) begin
      conv_mode <= next_mode;
      latch_sel <= next_latch;
      if (sel_i[0]) begin
        irq_polarity <= dat_i[`CFG_POL_BIT];
        fault_count  <= dat_i[`CFG_FC_MSB:`CFG_FC_LSB];
      end
      if (sel_i[1]) begin
        conversion_time <= dat_i[`CFG_CT_BIT];
        range_number    <= dat_i[`CFG_RN_MSB:`CFG_RN_LSB];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_limit  <= `LOW_RST;
      high_limit <= `HIGH_RST;
    end else if (ce_i && wr) begin
      if (adr_i == `LOW_OFS) begin
        if (sel_i[0]) begin
          low_limit[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          low_limit[15:8] <= dat_i[15:8];
        end
      end else if (adr_i == `HIGH_OFS) begin
        if (sel_i[0]) begin
          high_limit[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          high_limit[15:8] <= dat_i[15:8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_result <= `RES_RST;
    end else if (ce_i && meas_done_i) begin
      last_result <= result_i;
    end
  end

  // Sticky event bits, write one to clear; a new event beats the clear
  assign irq_ev[`IRQ_DONE] = meas_done_i;
  assign irq_ev[`IRQ_HIGH] = high_trip;
  assign irq_ev[`IRQ_LOW]  = low_trip;
  assign irq_clr = (wr && adr_i == `STAT_OFS && sel_i[0]) ?
                   dat_i[`IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else if (ce_i) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      if (wr && adr_i == `MASK_OFS && sel_i[0]) begin
        irq_mask <= dat_i[`IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Read mux; unmapped offsets answer with zero
  always_comb begin
    next_dat = 32'h0000_0000;
    if (adr_i == `CFG_OFS) begin
      next_dat[`CFG_FC_MSB:`CFG_FC_LSB] = fault_count;
      next_dat[`CFG_POL_BIT]            = irq_polarity;
      next_dat[`CFG_LATCH_BIT]          = latch_sel;
      next_dat[`CFG_FL_BIT]             = flag_low;
      next_dat[`CFG_FH_BIT]             = flag_high;
      next_dat[`CFG_CRF_BIT]            = conv_ready;
      next_dat[`CFG_M_MSB:`CFG_M_LSB]   = conv_mode;
      next_dat[`CFG_CT_BIT]             = conversion_time;
      next_dat[`CFG_RN_MSB:`CFG_RN_LSB] = range_number;
    end else if (adr_i == `LOW_OFS) begin
      next_dat[15:0] = low_limit;
    end else if (adr_i == `HIGH_OFS) begin
      next_dat[15:0] = high_limit;
    end else if (adr_i == `STAT_OFS) begin
      next_dat[`IRQ_W-1:0] = irq_stat;
    end else if (adr_i == `MASK_OFS) begin
      next_dat[`IRQ_W-1:0] = irq_mask;
    end else if (adr_i == `RES_OFS) begin
      next_dat[15:0] = last_result;
    end
  end

  // Data is captured at the same edge that applies read side effects,
  // so a config read returns the state before it was cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= wb_req;
      dat_o <= rd ? next_dat : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_eoc_every_conv: assert property (
    ce_i && meas_done_i && eoc_mode |=> int_active ##1 int_o == irq_polarity)
    else $error("end of conversion did not raise interrupt");

  a_eoc_read_drop: assert property (
    ce_i && eoc_mode && cfg_rd && !meas_done_i |=> !int_active)
    else $error("config read left interrupt active");

  a_high_latch: assert property (
    ce_i && latch_sel && meas_done_i && high_trip && !low_trip
    |=> flag_high && int_active && conv_ready
        && flag_low == $past(flag_low))
    else $error("high fault not latched");

  a_low_latch: assert property (
    ce_i && latch_sel && meas_done_i && low_trip && !high_trip
    |=> flag_low && int_active && conv_ready
        && flag_high == $past(flag_high))
    else $error("low fault not latched");

  a_ready_on_done: assert property (
    ce_i && meas_done_i && !high_trip && !low_trip
    |=> conv_ready && $stable(flag_high) && $stable(flag_low))
    else $error("conversion did not set ready");

  a_read_clears: assert property (
    ce_i && latch_sel && cfg_rd && !meas_done_i
    |=> !flag_high && !flag_low && !int_active && !conv_ready)
    else $error("config read did not clear state");

  a_shutdown_hold: assert property (
    ce_i && cfg_wr && !non_shut && !meas_done_i && next_latch == latch_sel
    |=> $stable(conv_ready) && $stable(int_active)
        && $stable(flag_high) && $stable(flag_low))
    else $error("shutdown write changed reporting state");

  a_run_write_ready: assert property (
    ce_i && cfg_wr && non_shut && latch_sel && next_latch && !meas_done_i
    |=> !conv_ready && $stable(int_active) && $stable(flag_high))
    else $error("run write mishandled ready");

  a_alert_drop: assert property (
    ce_i && latch_sel && alert_ev && !meas_done_i
    |=> !int_active && $stable(conv_ready) && $stable(flag_low))
    else $error("alert response mishandled");

  a_pin_level: assert property (
    ce_i |=> int_o == ($past(irq_polarity) ? $past(int_active)
                                           : !$past(int_active)))
    else $error("interrupt pin level wrong for polarity");

  a_bus_ack: assert property (
    ce_i && wb_req ##1 ce_i |=> !ack_o)
    else $error("ack held longer than one cycle");
  c_eoc_then_read: cover property (
    eoc_mode && meas_done_i ##[1:20] cfg_rd);
  c_high_fault: cover property (latch_sel && high_trip);
  c_transparent_low: cover property (!latch_sel && low_trip);
  c_alert: cover property (latch_sel && int_active && alert_ev);
endmodule

/* File: eoc_consts.svh */
`ifndef EOC_CONSTS_SVH
`define EOC_CONSTS_SVH

// Register byte offsets on the bus
`define CFG_OFS        8'h00
`define LOW_OFS        8'h04
`define HIGH_OFS       8'h08
`define STAT_OFS       8'h0C
`define MASK_OFS       8'h10
`define ALERT_OFS      8'h14
`define RES_OFS        8'h18

// Configuration register fields
`define CFG_FC_MSB     1
`define CFG_FC_LSB     0
`define CFG_POL_BIT    3
`define CFG_LATCH_BIT  4
`define CFG_FL_BIT     5
`define CFG_FH_BIT     6
`define CFG_CRF_BIT    7
`define CFG_M_MSB      10
`define CFG_M_LSB      9
`define CFG_CT_BIT     11
`define CFG_RN_MSB     15
`define CFG_RN_LSB     12

// Low limit exponent top bits and the code that selects end of conversion
`define LE_TOP_MSB     15
`define LE_TOP_LSB     14
`define EOC_CODE       2'h3

// Reset values
`define RN_RST         4'hC
`define CT_RST         1'h1
`define LATCH_RST      1'h1
`define LOW_RST        16'h0000
`define HIGH_RST       16'hBFFF
`define POL_RST        1'h0
`define FC_RST         2'h0
`define RES_RST        16'h0000

// Interrupt status and mask bits
`define IRQ_DONE       0
`define IRQ_HIGH       1
`define IRQ_LOW        2
`define IRQ_W          3

// Consecutive faults needed per fault count code
`define FC_N0          4'h1
`define FC_N1          4'h2
`define FC_N2          4'h4
`define FC_N3          4'h8

`endif

/* File: eoc_pkg.sv */
package eoc_pkg;

  typedef enum logic [1:0] {
    MODE_SHUTDOWN   = 2'h0,
    MODE_SINGLE     = 2'h1,
    MODE_CONTINUOUS = 2'h2,
    MODE_CONT_ALT   = 2'h3
  } conv_mode_t;

  typedef logic [15:0] limit_t;

endpackage

/* File: fault_filter.sv */
`timescale 1ns/1ps
`include "eoc_consts.svh"

module fault_filter
  import eoc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       meas_done_i,
  input  wire limit_t     result_i,
  input  wire limit_t     high_limit_i,
  input  wire limit_t     low_limit_i,
  input  wire logic [1:0] fault_count_i,
  output logic            high_trip_o,
  output logic            low_trip_o
);

  logic [3:0] need;
  logic [1:0] fault;
  logic [1:0] trip;

  always_comb begin
    case (fault_count_i)
      2'h0:    need = `FC_N0;
      2'h1:    need = `FC_N1;
      2'h2:    need = `FC_N2;
      default: need = `FC_N3;
    endcase
  end

  assign fault[0] = result_i > high_limit_i;
  assign fault[1] = result_i < low_limit_i;

  // One counter per direction; saturates so that every further
  // failing conversion trips again
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_dir
      logic [3:0] cnt;
      logic [3:0] next_cnt;
      assign next_cnt = cnt + 4'h1;
      assign trip[k] = meas_done_i & fault[k] & (next_cnt >= need);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt <= 4'h0;
        end else if (ce_i && meas_done_i) begin
          if (!fault[k]) begin
            cnt <= 4'h0;
          end else if (next_cnt >= need) begin
            cnt <= need;
          end else begin
            cnt <= next_cnt;
          end
        end
      end
    end
  endgenerate

  assign high_trip_o = trip[0];
  assign low_trip_o  = trip[1];

endmodule

/* File: host_model.sv */
`timescale 1ns/1ps

module host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end

  // Waits for ack however long it takes; the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [7:0] adr,
                      input logic [15:0] wdat, output logic [15:0] rdat,
                      output logic acked);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= wr;
    adr_o <= adr;
    sel_o <= 4'hF;
    dat_o <= {16'h0000, wdat};
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    rdat  = dat_i[15:0];
    acked = ack_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released lines carry junk, never the last value
    we_o  <= ~wr;
    adr_o <= ~adr;
    sel_o <= 4'h0;
    dat_o <= ~{16'h0000, wdat};
  endtask
endmodule

/* File: test_eoc_interrupt_reporting.sv */
`timescale 1ns/1ps
`include "eoc_consts.svh"

module test_eoc_interrupt_reporting
  import eoc_pkg::*;
();
  typedef struct {
    limit_t      res;
    logic [15:0] stat;
    logic [15:0] flags;
  } row_t;

  localparam logic [15:0] RUN  = 16'hCC10;
  localparam logic [15:0] SHUT = 16'hC810;
  localparam logic [15:0] TRN  = 16'hCC00;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        meas_done = 1'b0;
  limit_t      result = 16'h0000;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        int_pin;
  logic        irq;
  int          bad_count = 0;
  int          checks_done = 0;
  row_t        rows [5];

  always #2.5 clk = ~clk;

  eoc_interrupt_reporting i_eoc_interrupt_reporting (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .meas_done_i(meas_done), .result_i(result),
    .int_o(int_pin), .irq_o(irq)
  );

  host_model i_host_model (
    .clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat)
  );

  task automatic check16(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check1(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    logic [15:0] r;
    logic        ok;
    i_host_model.xfer(1'b1, a, d, r, ok);
    check1("write ack", 1'b1, ok);
  endtask

  task automatic rd_chk(string what, logic [7:0] a, logic [15:0] exp);
    logic [15:0] r;
    logic        ok;
    i_host_model.xfer(1'b0, a, 16'h0000, r, ok);
    check1("read ack", 1'b1, ok);
    check16(what, exp, r);
  endtask

  task automatic measure(limit_t r);
    @(posedge clk);
    meas_done <= 1'b1;
    result    <= r;
    @(posedge clk);
    meas_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Pins are registered, so give them two edges to land
  task automatic pins(logic exp_int, logic exp_irq);
    repeat (2) @(posedge clk);
    check1("int pin", exp_int, int_pin);
    check1("irq", exp_irq, irq);
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    rows[0] = '{16'hE001, 16'h0003, 16'h00C0};
    rows[1] = '{16'hC0FF, 16'h0005, 16'h00A0};
    rows[2] = '{16'hD000, 16'h0001, 16'h0080};
    rows[3] = '{16'hE000, 16'h0001, 16'h0080};
    rows[4] = '{16'hC100, 16'h0001, 16'h0080};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    pins(1'b1, 1'b0);
    rd_chk("config", `CFG_OFS, SHUT);
    rd_chk("low", `LOW_OFS, 16'h0000);
    rd_chk("high", `HIGH_OFS, 16'hBFFF);
    rd_chk("status", `STAT_OFS, 16'h0000);
    rd_chk("mask", `MASK_OFS, 16'h0000);
    wr(8'h1C, 16'hFFFF);
    rd_chk("unmapped", 8'h1C, 16'h0000);
    $display("test reset values done");
    // Host pairs end of conversion with latched reporting
    wr(`HIGH_OFS, 16'hE000);
    wr(`LOW_OFS, 16'hC100);
    wr(`MASK_OFS, 16'h0007);
    wr(`CFG_OFS, RUN);
    foreach (rows[i]) begin
      measure(rows[i].res);
      pins(1'b0, 1'b1);
      rd_chk("status", `STAT_OFS, rows[i].stat);
      wr(`STAT_OFS, 16'h0007);
      rd_chk("config", `CFG_OFS, RUN | rows[i].flags);
      pins(1'b1, 1'b0);
      rd_chk("config again", `CFG_OFS, RUN);
    end
    $display("test measurement rows done");
    measure(16'hE001);
    wr(`CFG_OFS, RUN);
    pins(1'b0, 1'b1);
    rd_chk("config", `CFG_OFS, RUN | 16'h0040);
    measure(16'hC0FF);
    measure(16'hE001);
    wr(`CFG_OFS, SHUT);
    pins(1'b0, 1'b1);
    rd_chk("config", `CFG_OFS, SHUT | 16'h00E0);
    $display("test config writes done");
    wr(`CFG_OFS, RUN);
    measure(16'hE001);
    wr(`ALERT_OFS, 16'h0000);
    pins(1'b1, 1'b1);
    rd_chk("config", `CFG_OFS, RUN | 16'h00C0);
    wr(`STAT_OFS, 16'h0007);
    $display("test alert done");
    wr(`CFG_OFS, RUN | 16'h0001);
    // High faults split by a pass do not count as consecutive; a pass resets them
    measure(16'hD000);
    measure(16'hE001);
    measure(16'hD000);
    measure(16'hE001);
    rd_chk("config", `CFG_OFS, RUN | 16'h0081);
    measure(16'hE001);
    rd_chk("config", `CFG_OFS, RUN | 16'h00C1);
    wr(`STAT_OFS, 16'h0007);
    $display("test fault count done");
    wr(`CFG_OFS, RUN | 16'h0008);
    pins(1'b0, 1'b0);
    measure(16'hD000);
    pins(1'b1, 1'b1);
    rd_chk("config", `CFG_OFS, RUN | 16'h0088);
    pins(1'b0, 1'b1);
    wr(`STAT_OFS, 16'h0007);
    $display("test polarity done");
    wr(`CFG_OFS, RUN);
    measure(16'hD000);
    wr(`LOW_OFS, 16'h0100);
    wr(`CFG_OFS, TRN);
    pins(1'b1, 1'b1);
    measure(16'hE001);
    pins(1'b0, 1'b1);
    rd_chk("config", `CFG_OFS, TRN | 16'h00C0);
    pins(1'b0, 1'b1);
    rd_chk("config again", `CFG_OFS, TRN | 16'h0040);
    $display("test leaving end of conversion done");
    // Clock enable low: a passing conversion must neither set ready nor update the result
    ce <= 1'b0;
    measure(16'hC0FF);
    ce <= 1'b1;
    pins(1'b0, 1'b1);
    rd_chk("config frozen", `CFG_OFS, TRN | 16'h0040);
    rd_chk("result", `RES_OFS, 16'hE001);
    $display("test clock enable done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pins(1'b1, 1'b0);
    rd_chk("config after reset", `CFG_OFS, SHUT);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
